// >>> core/agwm_cfg.svh
`ifndef AGWM_CFG_SVH
`define AGWM_CFG_SVH

// ==========================================================
// instruction field positions
`define AGWM_R1_MSB       4
`define AGWM_R1_LSB       0
`define AGWM_OPC_MSB      10
`define AGWM_OPC_LSB      5
`define AGWM_R2_MSB       15
`define AGWM_R2_LSB       11
`define AGWM_SIXTEEN_BIT_IMMEDIATE_MSB    31
`define AGWM_SIXTEEN_BIT_IMMEDIATE_LSB    16
`define AGWM_R3_MSB       31
`define AGWM_R3_LSB       27
`define AGWM_SUBR_MSB     26
`define AGWM_SUBR_LSB     16
`define AGWM_SUBIA_MSB    26
`define AGWM_SUBIA_LSB    22
`define AGWM_IMM9H_MSB    21
`define AGWM_IMM9H_LSB    18
`define AGWM_SUBIB_MSB    17
`define AGWM_SUBIB_LSB    16

// ==========================================================
// opcode and sub-opcode values
`define AGWM_OPC_EA       6'h31
`define AGWM_OPC_HH       6'h32
`define AGWM_OPC_MUL      6'h3f
`define AGWM_SUBR_VAL     11'h220
`define AGWM_SUBIA_VAL    5'h09
`define AGWM_SUBIB_VAL    2'h2

// ==========================================================
// register numbers and reset values
`define AGWM_ZERO_REG     5'h00
`define AGWM_STATE_RST    '0

`endif

// >>> core/agwm_pkg.sv
package agwm_pkg;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_EA,
		OP_HH,
		OP_MUL_R,
		OP_MUL_I
	} agwm_op_e;

	typedef struct packed {
		logic        valid;
		logic        lo_we;
		logic [4:0]  lo_idx;
		logic [31:0] lo_data;
		logic        hi_we;
		logic [4:0]  hi_idx;
		logic [31:0] hi_data;
		logic        flag_we;
		logic        unsupported;
	} agwm_state_s;

endpackage

// >>> core/agwm_mul_if.sv
`timescale 1ns/1ns

interface agwm_mul_if;
	logic [31:0] mcand;
	logic [31:0] mplier;
	logic [63:0] product;

	modport core (output mcand, output mplier, input product);
	modport unit (input mcand, input mplier, output product);
endinterface

// >>> core/agwm_mul.sv
`timescale 1ns/1ns

// ==========================================================
// signed 32x32 word multiplier, full 64-bit product
module agwm_mul (
	agwm_mul_if.unit mul // operand and product bundle
);
	logic [63:0] mcand_ext;
	logic [63:0] mplier_ext;

	// extend both operands by sign so the low 64 bits are the signed product
	assign mcand_ext  = {{32{mul.mcand[31]}}, mul.mcand};
	assign mplier_ext = {{32{mul.mplier[31]}}, mul.mplier};
	assign mul.product = mcand_ext * mplier_ext;
endmodule

// >>> core/agwm_core.sv
// Behaviour
// - effective-address add: source one plus sign-extended 16-bit immediate, opcode 110001
// - effective-address add writes its 32-bit result, never touching status flags
// - high-halfword add: source one plus immediate shifted to upper half, opcode 110010
// - high-halfword add leaves carry, overflow, sign, zero and saturation flags alone
// - immediate adds never write source one unless it is also destination
// - register multiply: second source times first source, 64-bit product to pair
// - immediate multiply: second source times sign-extended 9-bit immediate to pair
// - product upper word to third field, lower word to second field
// - when second and third fields match, that register ends with upper word
// - 9-bit immediate joins a 5-bit low field and 4-bit high field
`timescale 1ns/1ns
`include "agwm_cfg.svh"

module agwm_core (
	input  wire logic        CLK,         // core clock
	input  wire logic        RESET,       // async reset, active high
	input  wire logic        INSTR_VALID, // instruction presented this cycle
	input  wire logic [31:0] INSTR,       // instruction word
	input  wire logic [31:0] SRC1_DATA,   // value of first source field register
	input  wire logic [31:0] SRC2_DATA,   // value of second source field register
	output logic             RESULT_VALID, // one-cycle pulse, results below valid
	output logic             LO_WE,       // write lower/sum result
	output logic [4:0]       LO_IDX,      // register for lower/sum result
	output logic [31:0]      LO_DATA,     // lower/sum result
	output logic             HI_WE,       // write upper product word
	output logic [4:0]       HI_IDX,      // register for upper product word
	output logic [31:0]      HI_DATA,     // upper product word
	output logic             FLAG_WE,     // status word flag write, never raised
	output logic             UNSUPPORTED  // one-cycle pulse, instruction not handled
);
	agwm_pkg::agwm_state_s st_reg;
	agwm_pkg::agwm_state_s st_next;
	agwm_pkg::agwm_op_e    op;
	logic [4:0]            r1;
	logic [4:0]            r2;
	logic [4:0]            r3;
	logic [31:0]           nine_bit_immediate_ext;

	agwm_mul_if mul_bus ();

	// ==========================================================
	// decode helpers
	function automatic agwm_pkg::agwm_op_e decode(input logic [31:0] iw);
		logic [5:0] opc;
		opc = iw[`AGWM_OPC_MSB:`AGWM_OPC_LSB];
		if (opc == `AGWM_OPC_EA) begin
			return agwm_pkg::OP_EA;
		end else if (opc == `AGWM_OPC_HH) begin
			return agwm_pkg::OP_HH;
		end else if (opc == `AGWM_OPC_MUL &&
			iw[`AGWM_SUBR_MSB:`AGWM_SUBR_LSB] == `AGWM_SUBR_VAL) begin
			return agwm_pkg::OP_MUL_R;
		end else if (opc == `AGWM_OPC_MUL &&
			iw[`AGWM_SUBIA_MSB:`AGWM_SUBIA_LSB] == `AGWM_SUBIA_VAL &&
			iw[`AGWM_SUBIB_MSB:`AGWM_SUBIB_LSB] == `AGWM_SUBIB_VAL) begin
			return agwm_pkg::OP_MUL_I;
		end
		return agwm_pkg::OP_NONE;
	endfunction

	function automatic logic [31:0] sext16(input logic [31:0] iw);
		logic [15:0] imm;
		imm = iw[`AGWM_SIXTEEN_BIT_IMMEDIATE_MSB:`AGWM_SIXTEEN_BIT_IMMEDIATE_LSB];
		return {{16{imm[15]}}, imm};
	endfunction

	function automatic logic [31:0] upper16(input logic [31:0] iw);
		return {iw[`AGWM_SIXTEEN_BIT_IMMEDIATE_MSB:`AGWM_SIXTEEN_BIT_IMMEDIATE_LSB], 16'h0000};
	endfunction

	function automatic logic [31:0] sext9(input logic [31:0] iw);
		logic [8:0] imm;
		imm = {iw[`AGWM_IMM9H_MSB:`AGWM_IMM9H_LSB], iw[`AGWM_R1_MSB:`AGWM_R1_LSB]};
		return {{23{imm[8]}}, imm};
	endfunction

	// ==========================================================
	// multiplier
	assign op       = decode(INSTR);
	assign r1       = INSTR[`AGWM_R1_MSB:`AGWM_R1_LSB];
	assign r2       = INSTR[`AGWM_R2_MSB:`AGWM_R2_LSB];
	assign r3       = INSTR[`AGWM_R3_MSB:`AGWM_R3_LSB];
	assign nine_bit_immediate_ext = sext9(INSTR);

	assign mul_bus.mcand  = SRC2_DATA;
	assign mul_bus.mplier = (op == agwm_pkg::OP_MUL_I) ? nine_bit_immediate_ext : SRC1_DATA;

	agwm_mul u_mul (
		.mul (mul_bus.unit)
	);

	// ==========================================================
	// next state
	always_comb begin
		st_next = `AGWM_STATE_RST;
		// flag write stays low for every handled instruction
		st_next.flag_we = 1'b0;
		if (INSTR_VALID) begin
			unique case (op)
				agwm_pkg::OP_EA: begin
					st_next.valid   = 1'b1;
					// only the second field is written; source one changes only when it names the same register
					st_next.lo_we   = (r2 != `AGWM_ZERO_REG);
					st_next.lo_idx  = r2;
					st_next.lo_data = SRC1_DATA + sext16(INSTR);
				end
				agwm_pkg::OP_HH: begin
					st_next.valid   = 1'b1;
					st_next.lo_we   = (r2 != `AGWM_ZERO_REG);
					st_next.lo_idx  = r2;
					st_next.lo_data = SRC1_DATA + upper16(INSTR);
				end
				agwm_pkg::OP_MUL_R, agwm_pkg::OP_MUL_I: begin
					st_next.valid   = 1'b1;
					st_next.hi_we   = (r3 != `AGWM_ZERO_REG);
					st_next.hi_idx  = r3;
					st_next.hi_data = mul_bus.product[63:32];
					// lower word dropped when both fields name one register
					st_next.lo_we   = (r2 != `AGWM_ZERO_REG) && (r2 != r3);
					st_next.lo_idx  = r2;
					st_next.lo_data = mul_bus.product[31:0];
				end
				agwm_pkg::OP_NONE: begin
					st_next.unsupported = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			st_reg <= `AGWM_STATE_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign RESULT_VALID = st_reg.valid;
	assign LO_WE        = st_reg.lo_we;
	assign LO_IDX       = st_reg.lo_idx;
	assign LO_DATA      = st_reg.lo_data;
	assign HI_WE        = st_reg.hi_we;
	assign HI_IDX       = st_reg.hi_idx;
	assign HI_DATA      = st_reg.hi_data;
	assign FLAG_WE      = st_reg.flag_we;
	assign UNSUPPORTED  = st_reg.unsupported;

	// ==========================================================
	// assertions
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	sequence s_ea;
		INSTR_VALID && op == agwm_pkg::OP_EA;
	endsequence

	sequence s_hh;
		INSTR_VALID && op == agwm_pkg::OP_HH;
	endsequence

	sequence s_mul_r;
		INSTR_VALID && op == agwm_pkg::OP_MUL_R;
	endsequence

	sequence s_mul_i;
		INSTR_VALID && op == agwm_pkg::OP_MUL_I;
	endsequence

	sequence s_add_done;
		RESULT_VALID && !HI_WE && !FLAG_WE;
	endsequence

	AST_EA_SUM: assert property (s_ea |=>
		LO_DATA == $past(SRC1_DATA) + {{16{$past(INSTR[31])}}, $past(INSTR[31:16])})
		else $error("effective-address sum wrong");

	AST_EA_NOFLAG: assert property (s_ea |=> s_add_done)
		else $error("effective-address add touched flags or upper port");

	AST_HH_SUM: assert property (s_hh |=>
		LO_DATA == $past(SRC1_DATA) + {$past(INSTR[31:16]), 16'h0000})
		else $error("high-halfword sum wrong");

	AST_HH_NOFLAG: assert property (s_hh |=> s_add_done)
		else $error("high-halfword add touched flags");

	AST_ADD_DEST: assert property ((s_ea or s_hh) ##0 (r2 != 5'h00) |=>
		LO_WE && LO_IDX == $past(r2))
		else $error("immediate add wrote wrong register");

	AST_MUL_R: assert property (s_mul_r |=> {HI_DATA, LO_DATA} ==
		{{32{$past(SRC2_DATA[31])}}, $past(SRC2_DATA)} *
		{{32{$past(SRC1_DATA[31])}}, $past(SRC1_DATA)})
		else $error("register multiply product wrong");

	AST_MUL_I: assert property (s_mul_i |=> {HI_DATA, LO_DATA} ==
		{{32{$past(SRC2_DATA[31])}}, $past(SRC2_DATA)} *
		{{55{$past(INSTR[21])}}, $past(INSTR[21:18]), $past(INSTR[4:0])})
		else $error("immediate multiply product wrong");

	AST_MUL_DEST: assert property ((s_mul_r or s_mul_i) ##0 (r2 != r3) ##0
		(r2 != 5'h00) ##0 (r3 != 5'h00) |=>
		HI_WE && LO_WE && HI_IDX == $past(r3) && LO_IDX == $past(r2))
		else $error("multiply pair routing wrong");

	AST_MUL_SAME: assert property ((s_mul_r or s_mul_i) ##0 (r2 == r3) ##0
		(r3 != 5'h00) |=> HI_WE && !LO_WE && HI_IDX == $past(r2))
		else $error("shared multiply destination lost upper word");

	AST_NINE_BIT_IMMEDIATE: assert property (s_mul_i |->
		mul_bus.mplier[8:0] == {INSTR[21:18], INSTR[4:0]} &&
		mul_bus.mplier[31:9] == {23{INSTR[21]}})
		else $error("nine-bit immediate assembled wrong");

	AST_WRAP: assert property (s_ea ##0 (SRC1_DATA == 32'hffffffff) ##0
		(INSTR[31:16] == 16'h0001) |=> LO_DATA == 32'h00000000 && !FLAG_WE)
		else $error("sum did not wrap silently");

	AST_SIGNED: assert property (s_mul_r ##0 (SRC1_DATA == 32'hffffffff) ##0
		(SRC2_DATA == 32'h00000002) |=> HI_DATA == 32'hffffffff &&
		LO_DATA == 32'hfffffffe)
		else $error("multiply not signed");

	AST_IDLE: assert property (!INSTR_VALID |=> !RESULT_VALID && !LO_WE && !HI_WE &&
		!UNSUPPORTED)
		else $error("output without instruction");
endmodule

// >>> verif/agwm_rf_model.sv
`timescale 1ns/1ns

// ==========================================================
// register file read side of the core, fixed contents
module agwm_rf_model (
	input  wire logic [31:0] instr, // instruction under issue
	output logic      [31:0] src1,  // first source field read
	output logic      [31:0] src2   // second field read
);
	logic [31:0] regs [32];

	initial begin
		for (int i = 0; i < 32; i++) begin
			regs[i] = 32'h7fff0000 ^ (i * 32'h1b873593);
		end
		regs[0] = 32'h0;
		// all-ones and small positive words reach the wrap and sign corners
		regs[2] = 32'h00000002;
		regs[29] = 32'hffffffff;
		regs[30] = 32'h7fffffff;
		regs[31] = 32'h80000000;
	end

	// same-cycle reads, as the register file presents them
	assign src1 = regs[instr[4:0]];
	assign src2 = regs[instr[15:11]];
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ns

module tb;
	typedef struct packed {
		logic        unsup;
		logic        lo_we;
		logic [4:0]  lo_idx;
		logic [31:0] lo_data;
		logic        hi_we;
		logic [4:0]  hi_idx;
		logic [31:0] hi_data;
	} agwm_exp_s;

	logic        CLK, RESET, INSTR_VALID, RESULT_VALID, LO_WE, HI_WE, FLAG_WE, UNSUPPORTED;
	logic [31:0] INSTR, SRC1_DATA, SRC2_DATA, LO_DATA, HI_DATA;
	logic [4:0]  LO_IDX, HI_IDX;
	agwm_exp_s   exp_q[$];
	agwm_exp_s   got;
	logic [31:0] lf;
	int          miscompares = 0;
	int          n_tests = 0;

	agwm_core dut (.CLK(CLK), .RESET(RESET), .INSTR_VALID(INSTR_VALID), .INSTR(INSTR),
		.SRC1_DATA(SRC1_DATA), .SRC2_DATA(SRC2_DATA), .RESULT_VALID(RESULT_VALID),
		.LO_WE(LO_WE), .LO_IDX(LO_IDX), .LO_DATA(LO_DATA), .HI_WE(HI_WE), .HI_IDX(HI_IDX),
		.HI_DATA(HI_DATA), .FLAG_WE(FLAG_WE), .UNSUPPORTED(UNSUPPORTED));
	agwm_rf_model rf (.instr(INSTR), .src1(SRC1_DATA), .src2(SRC2_DATA));

	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] gt);
		n_tests++;
		if (gt !== ex) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, gt);
		end
	endtask

	// k: 0 ea add, 1 high add, 2 reg multiply, 3 imm multiply, else undecoded
	task automatic issue(input int k, input logic [4:0] a, input logic [4:0] b,
		input logic [4:0] c, input logic [15:0] im);
		logic [31:0] w, s1, s2, op;
		logic [63:0] p;
		agwm_exp_s   e;
		case (k)
			0: w = {im, b, 6'h31, a};
			1: w = {im, b, 6'h32, a};
			2: w = {c, 11'h220, b, 6'h3f, a};
			3: w = {c, 5'h09, im[8:5], 2'h2, b, 6'h3f, im[4:0]};
			default: w = {c, 11'h000, b, 6'h00, a};
		endcase
		s1 = rf.regs[w[4:0]];
		s2 = rf.regs[b];
		e = '0;
		if (k < 2) begin
			e.lo_we = (b != 5'h00);
			e.lo_idx = b;
			e.lo_data = s1 + ((k == 0) ? {{16{im[15]}}, im} : {im, 16'h0000});
		end else if (k < 4) begin
			op = (k == 2) ? s1 : {{23{im[8]}}, im[8:0]};
			p = {{32{s2[31]}}, s2} * {{32{op[31]}}, op};
			e.hi_we = (c != 5'h00);
			e.hi_idx = c;
			e.hi_data = p[63:32];
			e.lo_we = (b != 5'h00) && (b != c);
			e.lo_idx = b;
			e.lo_data = p[31:0];
		end else begin
			e.unsup = 1'b1;
		end
		@(posedge CLK);
		INSTR_VALID <= 1'b1;
		INSTR <= w;
		exp_q.push_back(e);
	endtask

	always @(posedge CLK) begin
		if (RESULT_VALID === 1'b1 || UNSUPPORTED === 1'b1) begin
			got = (exp_q.size() > 0) ? exp_q.pop_front() : '1;
			chk("unsupported", {31'h0, got.unsup}, {31'h0, UNSUPPORTED});
			chk("result_valid", {31'h0, ~got.unsup}, {31'h0, RESULT_VALID});
			chk("flag_we", 32'h0, {31'h0, FLAG_WE});
			chk("lo_we", {31'h0, got.lo_we}, {31'h0, LO_WE});
			if (got.lo_we) chk("lo_idx", {27'h0, got.lo_idx}, {27'h0, LO_IDX});
			if (got.lo_we) chk("lo_data", got.lo_data, LO_DATA);
			chk("hi_we", {31'h0, got.hi_we}, {31'h0, HI_WE});
			if (got.hi_we) chk("hi_idx", {27'h0, got.hi_idx}, {27'h0, HI_IDX});
			if (got.hi_we) chk("hi_data", got.hi_data, HI_DATA);
		end
	end

	task automatic complete_run;
		$display("mismatches %0d of %0d checks", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		#20000;
		miscompares++;
		complete_run;
	end

	initial begin
		logic [4:0] a, b, c;
		RESET = 1'b1;
		INSTR_VALID = 1'b0;
		INSTR = 32'h0;
		lf = 32'h9a2f;
		repeat (10) @(posedge CLK);
		RESET <= 1'b0;
		issue(0, 5'd30, 5'd5, 5'd0, 16'h0001);
		issue(0, 5'd29, 5'd5, 5'd0, 16'h0001);
		issue(2, 5'd29, 5'd2, 5'd3, 16'h0000);
		issue(0, 5'd31, 5'd5, 5'd0, 16'hffff);
		issue(1, 5'd30, 5'd7, 5'd0, 16'h8000);
		issue(2, 5'd31, 5'd9, 5'd9, 16'h0000);
		issue(3, 5'd0, 5'd30, 5'd12, 16'h0100);
		issue(3, 5'd0, 5'd31, 5'd12, 16'h00ff);
		issue(4, 5'd3, 5'd4, 5'd5, 16'h0000);
		repeat (300) begin
			lf = lfsr(lf);
			a = lf[4:0];
			b = (lf[9:5] == 5'h00) ? 5'h01 : lf[9:5];
			c = (lf[14:10] == 5'h00) ? 5'h02 : lf[14:10];
			if (a == c && a != b) c = b;
			issue(int'(lf[18:16]) % 5, a, b, c, lf[31:16]);
		end
		@(posedge CLK);
		INSTR_VALID <= 1'b0;
		repeat (3) @(posedge CLK);
		chk("pending", 32'h0, exp_q.size());
		complete_run;
	end
endmodule
